// ### hw/flow_pkg.sv
package flow_pkg;
	// ****************************************************************
	// Opcodes and field layout
	// ****************************************************************
	localparam logic [7:0] OP_RESTART = 8'h30; // Restart at label, decimal 48.
	localparam logic [7:0] OP_DEC_BRANCH = 8'h31; // Decrement and branch, decimal 49.
	localparam logic [7:0] OP_COND_CALL = 8'h15; // Conditional call, decimal 21.
	localparam logic [7:0] STATUS_OK = 8'h64; // Success status, decimal 100.
	localparam logic [7:0] STATUS_BAD_CMD = 8'h02; // Opcode not served here.
	localparam logic [7:0] STATUS_BAD_SUM = 8'h01; // Checksum mismatch.
	localparam logic [7:0] HOST_ADDR = 8'h02; // Address of the host in replies.
	localparam int FRAME_BYTES = 9; // Bytes in a command frame, checksum included.
	localparam int REPLY_BYTES = 9; // Bytes in a reply frame, checksum included.
	localparam int STACK_DEPTH = 8; // Return stack entries.
	localparam int VAR_COUNT = 256; // User variables.
	localparam logic [31:0] PC_RESET = 32'h0000_0000; // Program counter after reset.

	// ****************************************************************
	// Condition codes
	// ****************************************************************
	typedef enum logic [3:0] {
		cond_zero = 4'h0,
		cond_not_zero = 4'h1,
		cond_equal = 4'h2,
		cond_not_equal = 4'h3,
		cond_greater = 4'h4,
		cond_greater_equal = 4'h5,
		cond_lower = 4'h6,
		cond_lower_equal = 4'h7,
		cond_timeout_error = 4'h8,
		cond_external_alarm = 4'h9,
		cond_deviation_error = 4'ha,
		cond_position_error = 4'hb
	} cond_type;
endpackage

// ### hw/var_if.sv
`timescale 1ns/1ps
// Port between the sequencer and its user-variable memory.
interface var_if;
	logic [7:0] rd_addr; // Variable read index.
	logic [31:0] rd_data; // Registered read data, valid one cycle after rd_addr.
	logic wr_en; // Write strobe.
	logic [7:0] wr_addr; // Variable write index.
	logic [31:0] wr_data; // Write data.
	modport master (output rd_addr, output wr_en, output wr_addr, output wr_data, input rd_data);
	modport mem (input rd_addr, input wr_en, input wr_addr, input wr_data, output rd_data);
endinterface

// ### hw/var_mem.sv
`timescale 1ns/1ps
// User-variable store; read data come out of a register.
module var_mem #(
	parameter int DEPTH = flow_pkg::VAR_COUNT
) (
	input wire logic mclk,
	var_if.mem port
);
	// ****************************************************************
	// Storage
	// ****************************************************************
	// Variables power up as zero and are not touched by reset, as in a real RAM.
	// A known start keeps a first decrement from steering the program counter into unknowns.
	logic [31:0] mem_ff [DEPTH] = '{default: 32'h0};
	logic [31:0] rd_ff; // Registered read word.

	initial begin
		if (DEPTH != 256) $error("var_mem: depth must be 256 for 8-bit indices");
	end

	// Write and read are both synchronous; write-first is not promised.
	always_ff @(posedge mclk) begin
		if (port.wr_en) begin
			mem_ff[port.wr_addr] <= port.wr_data;
		end
		rd_ff <= mem_ff[port.rd_addr];
	end

	assign port.rd_data = rd_ff;
endmodule

// ### hw/program_flow_sequencer.sv
`timescale 1ns/1ps
// Behaviour
// RULE1: Restart opcode 48 resumes at given label.
// RULE2: Restart empties stacks, clears registers, then loads.
// RULE3: Restart acts same at any nesting level.
// RULE4: Opcode 49 takes variable index, branch target.
// RULE5: Decrement variable; branch only if result nonzero.
// RULE6: Opcode 21 true: push PC, load target.
// RULE7: Call false: next instruction, stack untouched.
// RULE8: Return stack holds at most eight entries.
// RULE9: Call with full stack ignored entirely.
// RULE10: Codes 0-7 test comparison flags.
// RULE11: Codes 8-11 test the four error flags.
// RULE12: Host uses these only in stored programs; the code also executes them from host frames.
// RULE13: Direct-mode success reply carries status 100.
// RULE14: Frames end in byte-sum checksum, value MSB first.
module program_flow_sequencer #(
	parameter int DEPTH = flow_pkg::STACK_DEPTH
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic run_valid, // Stored-program instruction offered.
	input wire logic [7:0] run_opcode,
	input wire logic [7:0] run_type,
	input wire logic [31:0] run_value,
	output logic run_ready, // Instruction taken when valid and ready.
	input wire logic rx_valid, // Host frame byte strobe.
	input wire logic [7:0] rx_byte,
	output logic tx_valid, // Reply byte strobe, one cycle per byte.
	output logic [7:0] tx_byte,
	input wire logic flag_zero, // Comparison flags from the arithmetic unit.
	input wire logic flag_equal,
	input wire logic flag_greater,
	input wire logic flag_lower,
	input wire logic err_timeout,
	input wire logic err_alarm,
	input wire logic err_deviation,
	input wire logic err_position,
	output logic [31:0] pc, // Program counter.
	output logic [3:0] stack_level, // Return-stack fill.
	output logic [3:0] irq_level, // Interrupt-stack fill, emptied on restart.
	output logic clear_regs // One-cycle pulse: clear accumulator and X register.
);
	// ****************************************************************
	// Types and state
	// ****************************************************************
	typedef enum logic [2:0] {
		st_idle = 3'b000,
		st_read = 3'b001,
		st_dec = 3'b010,
		st_reply = 3'b011
	} state_type;

	state_type state_ff, nxt_state; // Execution state.
	logic [31:0] pc_ff, nxt_pc; // Program counter.
	logic [31:0] stack_ff [DEPTH]; // Return addresses.
	logic [31:0] nxt_stack [DEPTH];
	logic [3:0] sp_ff, nxt_sp; // Number of stacked entries.
	logic [3:0] isp_ff, nxt_isp; // Interrupt stack depth, only cleared here.
	logic clr_ff, nxt_clr; // Register clear pulse.
	logic [7:0] var_idx_ff, nxt_var_idx; // Variable under decrement.
	logic [31:0] tgt_ff, nxt_tgt; // Branch target held during decrement.
	logic direct_ff, nxt_direct; // Current instruction came from the host.
	logic [7:0] status_ff, nxt_status; // Status for the reply.
	logic [7:0] cmd_op_ff, nxt_cmd_op; // Opcode echoed in reply.
	logic [31:0] reply_val_ff, nxt_reply_val; // Value echoed in reply.
	logic [7:0] rx_buf_ff [flow_pkg::FRAME_BYTES]; // Collected frame bytes.
	logic [7:0] nxt_rx_buf [flow_pkg::FRAME_BYTES];
	logic [3:0] rx_cnt_ff, nxt_rx_cnt; // Bytes collected.
	logic [7:0] rx_sum_ff, nxt_rx_sum; // Running byte sum.
	logic [3:0] tx_cnt_ff, nxt_tx_cnt; // Reply byte index.
	logic [7:0] tx_sum_ff, nxt_tx_sum; // Running reply sum.
	logic tx_valid_ff, nxt_tx_valid;
	logic [7:0] tx_byte_ff, nxt_tx_byte;
	logic frame_done; // A full frame with good checksum is present.
	logic frame_bad; // A full frame with bad checksum is present.
	logic [7:0] ex_op, ex_type; // Instruction now offered for execution.
	logic [31:0] ex_val;

	var_if vars ();

	var_mem #(.DEPTH(flow_pkg::VAR_COUNT)) u_vars (
		.mclk(mclk),
		.port(vars)
	);

	initial begin
		// The push index uses three bits of the fill count, so deeper stacks are refused.
		if (DEPTH < 1 || DEPTH > 8) $error("stack depth must be 1 to 8");
	end

	// ****************************************************************
	// Condition evaluation
	// ****************************************************************
	// Decodes one condition code against the live flags; unknown codes fail.
	function automatic logic cond_met(input logic [7:0] code, input logic z, input logic e,
			input logic g, input logic l, input logic [3:0] errs);
		logic r;
		r = 1'b0;
		if (code[7:4] == 4'h0) begin
			case (flow_pkg::cond_type'(code[3:0]))
				flow_pkg::cond_zero: r = z; // RULE10
				flow_pkg::cond_not_zero: r = !z; // RULE10
				flow_pkg::cond_equal: r = e; // RULE10
				flow_pkg::cond_not_equal: r = !e; // RULE10
				flow_pkg::cond_greater: r = g; // RULE10
				flow_pkg::cond_greater_equal: r = g || e; // RULE10
				flow_pkg::cond_lower: r = l; // RULE10
				flow_pkg::cond_lower_equal: r = l || e; // RULE10
				flow_pkg::cond_timeout_error: r = errs[0]; // RULE11
				flow_pkg::cond_external_alarm: r = errs[1]; // RULE11
				flow_pkg::cond_deviation_error: r = errs[2]; // RULE11
				flow_pkg::cond_position_error: r = errs[3]; // RULE11
				default: r = 1'b0;
			endcase
		end
		return r;
	endfunction

	// ****************************************************************
	// Frame receive and instruction select
	// ****************************************************************
	// Host frames win over stored-program instructions; the program waits.
	always_comb begin
		frame_done = (rx_cnt_ff == 4'(flow_pkg::FRAME_BYTES)) && (rx_sum_ff == rx_buf_ff[8]);
		frame_bad = (rx_cnt_ff == 4'(flow_pkg::FRAME_BYTES)) && (rx_sum_ff != rx_buf_ff[8]);
		if (frame_done || frame_bad) begin
			ex_op = rx_buf_ff[1];
			ex_type = rx_buf_ff[2];
			ex_val = {rx_buf_ff[4], rx_buf_ff[5], rx_buf_ff[6], rx_buf_ff[7]}; // RULE14
		end else begin
			ex_op = run_opcode;
			ex_type = run_type;
			ex_val = run_value;
		end
		run_ready = (state_ff == st_idle) && !frame_done && !frame_bad;
	end

	// ****************************************************************
	// Next-state logic
	// ****************************************************************
	// Bytes arriving while a frame is pending or a reply runs are dropped.
	always_comb begin
		nxt_state = state_ff;
		nxt_pc = pc_ff;
		nxt_stack = stack_ff;
		nxt_sp = sp_ff;
		nxt_isp = isp_ff;
		nxt_clr = 1'b0;
		nxt_var_idx = var_idx_ff;
		nxt_tgt = tgt_ff;
		nxt_direct = direct_ff;
		nxt_status = status_ff;
		nxt_cmd_op = cmd_op_ff;
		nxt_reply_val = reply_val_ff;
		nxt_rx_buf = rx_buf_ff;
		nxt_rx_cnt = rx_cnt_ff;
		nxt_rx_sum = rx_sum_ff;
		nxt_tx_cnt = tx_cnt_ff;
		nxt_tx_sum = tx_sum_ff;
		nxt_tx_valid = 1'b0;
		nxt_tx_byte = tx_byte_ff;
		vars.rd_addr = var_idx_ff;
		vars.wr_en = 1'b0;
		vars.wr_addr = var_idx_ff;
		vars.wr_data = vars.rd_data - 32'h1;
		if (rx_valid && rx_cnt_ff < 4'(flow_pkg::FRAME_BYTES) && state_ff != st_reply) begin
			nxt_rx_buf[rx_cnt_ff] = rx_byte;
			nxt_rx_cnt = rx_cnt_ff + 4'h1;
			if (rx_cnt_ff < 4'(flow_pkg::FRAME_BYTES - 1)) begin
				nxt_rx_sum = rx_sum_ff + rx_byte; // RULE14
			end
		end
		case (state_ff)
			st_idle: begin
				if (frame_done || frame_bad || run_valid) begin
					nxt_direct = frame_done || frame_bad;
					nxt_cmd_op = ex_op;
					nxt_reply_val = ex_val;
					nxt_status = flow_pkg::STATUS_OK; // RULE13
					if (frame_done || frame_bad) begin
						nxt_rx_cnt = 4'h0;
						nxt_rx_sum = 8'h00;
						nxt_state = st_reply;
						nxt_tx_cnt = 4'h0;
						nxt_tx_sum = 8'h00;
					end
					if (frame_bad) begin
						nxt_status = flow_pkg::STATUS_BAD_SUM;
					end else if (ex_op == flow_pkg::OP_RESTART) begin // RULE1 RULE3
						for (int i = 0; i < DEPTH; i++) begin
							nxt_stack[i] = 32'h0;
						end
						nxt_sp = 4'h0; // RULE2
						nxt_isp = 4'h0; // RULE2
						nxt_clr = 1'b1; // RULE2
						nxt_pc = ex_val; // RULE1
					end else if (ex_op == flow_pkg::OP_DEC_BRANCH) begin // RULE4
						nxt_var_idx = ex_type;
						nxt_tgt = ex_val;
						nxt_state = st_read;
					end else if (ex_op == flow_pkg::OP_COND_CALL) begin
						if (cond_met(ex_type, flag_zero, flag_equal, flag_greater, flag_lower,
								{err_position, err_deviation, err_alarm, err_timeout})
								&& sp_ff < 4'(DEPTH)) begin // RULE8 RULE9
							nxt_stack[sp_ff[2:0]] = pc_ff + 32'h1; // RULE6
							nxt_sp = sp_ff + 4'h1; // RULE6
							nxt_pc = ex_val; // RULE6
						end else begin
							nxt_pc = pc_ff + 32'h1; // RULE7 RULE9
						end
					end else begin
						nxt_status = flow_pkg::STATUS_BAD_CMD;
					end
				end
			end
			st_read: begin
				nxt_state = st_dec;
			end
			st_dec: begin
				vars.wr_en = 1'b1; // RULE5
				nxt_reply_val = vars.rd_data - 32'h1;
				nxt_pc = (vars.rd_data != 32'h1) ? tgt_ff : pc_ff + 32'h1; // RULE5
				nxt_state = direct_ff ? st_reply : st_idle;
			end
			st_reply: begin
				nxt_tx_valid = 1'b1;
				nxt_tx_cnt = tx_cnt_ff + 4'h1;
				case (tx_cnt_ff)
					4'h0: nxt_tx_byte = flow_pkg::HOST_ADDR;
					4'h1: nxt_tx_byte = rx_buf_ff[0];
					4'h2: nxt_tx_byte = status_ff;
					4'h3: nxt_tx_byte = cmd_op_ff;
					4'h4: nxt_tx_byte = reply_val_ff[31:24]; // RULE14
					4'h5: nxt_tx_byte = reply_val_ff[23:16];
					4'h6: nxt_tx_byte = reply_val_ff[15:8];
					4'h7: nxt_tx_byte = reply_val_ff[7:0];
					default: nxt_tx_byte = tx_sum_ff; // RULE14
				endcase
				nxt_tx_sum = tx_sum_ff + nxt_tx_byte;
				if (tx_cnt_ff == 4'(flow_pkg::REPLY_BYTES - 1)) begin
					nxt_state = st_idle;
				end
			end
			default: nxt_state = st_idle;
		endcase
	end

	// ****************************************************************
	// State registers
	// ****************************************************************
	// Only registers here; all decisions live in the process above.
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= st_idle;
			pc_ff <= flow_pkg::PC_RESET;
			for (int i = 0; i < DEPTH; i++) begin
				stack_ff[i] <= 32'h0;
			end
			for (int i = 0; i < flow_pkg::FRAME_BYTES; i++) begin
				rx_buf_ff[i] <= 8'h00;
			end
			sp_ff <= 4'h0;
			isp_ff <= 4'h0;
			clr_ff <= 1'b0;
			var_idx_ff <= 8'h00;
			tgt_ff <= 32'h0;
			direct_ff <= 1'b0;
			status_ff <= 8'h00;
			cmd_op_ff <= 8'h00;
			reply_val_ff <= 32'h0;
			rx_cnt_ff <= 4'h0;
			rx_sum_ff <= 8'h00;
			tx_cnt_ff <= 4'h0;
			tx_sum_ff <= 8'h00;
			tx_valid_ff <= 1'b0;
			tx_byte_ff <= 8'h00;
		end else begin
			state_ff <= nxt_state;
			pc_ff <= nxt_pc;
			stack_ff <= nxt_stack;
			rx_buf_ff <= nxt_rx_buf;
			sp_ff <= nxt_sp;
			isp_ff <= nxt_isp;
			clr_ff <= nxt_clr;
			var_idx_ff <= nxt_var_idx;
			tgt_ff <= nxt_tgt;
			direct_ff <= nxt_direct;
			status_ff <= nxt_status;
			cmd_op_ff <= nxt_cmd_op;
			reply_val_ff <= nxt_reply_val;
			rx_cnt_ff <= nxt_rx_cnt;
			rx_sum_ff <= nxt_rx_sum;
			tx_cnt_ff <= nxt_tx_cnt;
			tx_sum_ff <= nxt_tx_sum;
			tx_valid_ff <= nxt_tx_valid;
			tx_byte_ff <= nxt_tx_byte;
		end
	end

	assign pc = pc_ff;
	assign stack_level = sp_ff;
	assign irq_level = isp_ff;
	assign clear_regs = clr_ff;
	assign tx_valid = tx_valid_ff;
	assign tx_byte = tx_byte_ff;
endmodule

// ### tb/flow_sva.sv
`timescale 1ns/1ps
// Port checks of the sequencer.
module flow_sva #(
	parameter int DEPTH = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic run_valid,
	input wire logic run_ready,
	input wire logic [7:0] run_opcode,
	input wire logic [7:0] run_type,
	input wire logic [31:0] run_value,
	input wire logic flag_zero,
	input wire logic err_timeout,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte,
	input wire logic [31:0] pc,
	input wire logic [3:0] stack_level,
	input wire logic [3:0] irq_level,
	input wire logic clear_regs
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	logic go; // An instruction is taken on this edge.
	logic rs; // A restart is taken.
	logic cl; // A call is taken.
	assign go = run_valid && run_ready;
	assign rs = go && run_opcode == flow_pkg::OP_RESTART;
	assign cl = go && run_opcode == flow_pkg::OP_COND_CALL;
	a_restart_load: assert property (rs |=> pc == $past(run_value) && stack_level == 4'h0)
		else $error("restart target not loaded");
	a_restart_clear: assert property (rs |=> irq_level == 4'h0 && clear_regs)
		else $error("restart did not clear state");
	a_stack_max: assert property (stack_level <= DEPTH)
		else $error("return stack overfilled");
	a_call_step: assert property (cl |=> (pc == $past(run_value)
		&& stack_level == $past(stack_level) + 4'h1)
		|| (pc == $past(pc) + 32'h1 && $stable(stack_level)))
		else $error("call neither pushed nor stepped");
	a_full_ignore: assert property (cl && stack_level == DEPTH
		|=> pc == $past(pc) + 32'h1 && $stable(stack_level))
		else $error("call on full stack acted");
	a_zero_cond: assert property (cl && run_type == 8'h00 && flag_zero
		&& stack_level < DEPTH |=> pc == $past(run_value))
		else $error("zero condition missed");
	a_timeout_cond: assert property (cl && run_type == 8'h08 && err_timeout
		&& stack_level < DEPTH |=> stack_level == $past(stack_level) + 4'h1)
		else $error("timeout condition missed");
	a_dec_stall: assert property (go && run_opcode == flow_pkg::OP_DEC_BRANCH
		|=> !run_ready ##1 !run_ready ##[1:2] run_ready)
		else $error("decrement stall length wrong");
	a_reply_frame: assert property ($rose(tx_valid) |->
		tx_byte == flow_pkg::HOST_ADDR ##1 tx_valid [*8] ##1 !tx_valid)
		else $error("reply frame length wrong");
endmodule
bind program_flow_sequencer flow_sva #(.DEPTH(DEPTH)) chk (.mclk, .nrst, .run_valid,
	.run_ready, .run_opcode, .run_type, .run_value, .flag_zero, .err_timeout, .tx_valid,
	.tx_byte, .pc, .stack_level, .irq_level, .clear_regs);

// ### tb/host_model.sv
`timescale 1ns/1ps
// Host that sends command frames and keeps the reply bytes.
module host_model (
	input wire logic mclk,
	output logic rx_valid,
	output logic [7:0] rx_byte,
	input wire logic tx_valid,
	input wire logic [7:0] tx_byte
);
	logic [7:0] rq[$]; // Reply bytes in arrival order.
	initial begin
		rx_valid = 1'b0;
		rx_byte = 8'h00;
	end
	// Every reply byte stands one cycle, so take it on its edge.
	always @(posedge mclk) begin
		if (tx_valid === 1'b1) begin
			rq.push_back(tx_byte);
		end
	end
	// Send one frame; bad spoils the checksum on purpose.
	task automatic send(input logic [7:0] op, input logic [31:0] v, input logic bad);
		logic [7:0] f[9];
		f = '{8'h01, op, 8'h00, 8'h00, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
		for (int i = 0; i < 8; i++) f[8] += f[i];
		f[8] = f[8] + bad;
		rq.delete();
		for (int i = 0; i < 9; i++) begin
			@(negedge mclk);
			rx_valid = 1'b1;
			rx_byte = f[i];
			@(negedge mclk);
			rx_valid = 1'b0;
			rx_byte = ~f[i]; // A stale byte must not look valid.
		end
	endtask
endmodule

// ### tb/program_flow_sequencer_bench.sv
`timescale 1ns/1ps
// Self-checking bench for the sequencer.
module program_flow_sequencer_bench;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic run_valid = 1'b0;
	logic run_ready, tx_valid, rx_valid, clear_regs;
	logic flag_zero, flag_equal, flag_greater, flag_lower;
	logic err_timeout, err_alarm, err_deviation, err_position;
	logic [7:0] run_opcode = 8'h00;
	logic [7:0] run_type = 8'h00;
	logic [7:0] rx_byte, tx_byte;
	logic [31:0] run_value = 32'h0;
	logic [31:0] pc;
	logic [3:0] stack_level, irq_level;
	int mismatches = 0;
	int cmp_count = 0;
	int cyc = 0;
	always #50 mclk = ~mclk;
	program_flow_sequencer uut (.mclk, .nrst, .run_valid, .run_opcode, .run_type, .run_value,
		.run_ready, .rx_valid, .rx_byte, .tx_valid, .tx_byte, .flag_zero, .flag_equal,
		.flag_greater, .flag_lower, .err_timeout, .err_alarm, .err_deviation, .err_position,
		.pc, .stack_level, .irq_level, .clear_regs);
	host_model hm (.mclk, .rx_valid, .rx_byte, .tx_valid, .tx_byte);
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		cmp_count++;
		if (s !== e) begin
			mismatches++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic test_done();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// A hang is cut short well past the few hundred cycles the run needs.
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			test_done();
		end
	end
	// Offers one instruction; returns at the falling edge after it was taken.
	task automatic issue(input logic [7:0] op, input logic [7:0] ty, input logic [31:0] v);
		@(negedge mclk);
		run_valid = 1'b1;
		run_opcode = op;
		run_type = ty;
		run_value = v;
		while (run_ready !== 1'b1) @(negedge mclk);
		@(negedge mclk);
		run_valid = 1'b0;
	endtask
	task automatic t_restart(input logic [31:0] a);
		issue(flow_pkg::OP_RESTART, 8'h00, a);
		chk("pc", pc, a);
		chk("stack", stack_level, 32'h0);
		chk("irq", irq_level, 32'h0);
		chk("clear", clear_regs, 32'h1);
		@(negedge mclk);
		chk("clear end", clear_regs, 32'h0);
	endtask
	// Every condition code once, the four unused codes too, with all flags low or all high.
	task automatic t_cond(input logic [7:0] f);
		logic [31:0] p;
		logic [3:0] l;
		logic h;
		logic [11:0] tv;
		{err_position, err_deviation, err_alarm, err_timeout} = f[7:4];
		{flag_lower, flag_greater, flag_equal, flag_zero} = f[3:0];
		tv = {f[7:4], f[3] | f[1], f[3], f[2] | f[1], f[2], ~f[1], f[1], ~f[0], f[0]};
		for (int c = 0; c < 16; c++) begin
			p = pc;
			l = stack_level;
			h = c < 12 && tv[c] && l < 4'h8;
			issue(flow_pkg::OP_COND_CALL, 8'(c), 32'h100 + c);
			chk("call pc", pc, h ? 32'h100 + c : p + 32'h1);
			chk("call level", stack_level, l + h);
		end
	endtask
	// A fresh variable holds zero, so its decrement is nonzero and must branch.
	task automatic t_dec();
		issue(flow_pkg::OP_DEC_BRANCH, 8'h2a, 32'h1);
		chk("dec ready", run_ready, 32'h0);
		@(negedge mclk);
		chk("dec stall", run_ready, 32'h0);
		@(negedge mclk);
		chk("dec pc", pc, 32'h1);
		chk("dec done", run_ready, 32'h1);
	endtask
	// The reply echoes rv: the command value, or the decremented variable.
	task automatic t_host(input logic [7:0] op, input logic [31:0] v, input logic bad,
		input logic [7:0] st, input logic [31:0] rv);
		logic [7:0] e[8];
		logic [7:0] s;
		logic [31:0] p;
		p = pc;
		s = 8'h00;
		e = '{flow_pkg::HOST_ADDR, 8'h01, st, op, rv[31:24], rv[23:16], rv[15:8], rv[7:0]};
		hm.send(op, v, bad);
		for (int k = 0; k < 40 && hm.rq.size() < 9; k++) @(negedge mclk);
		chk("reply size", hm.rq.size(), 32'h9);
		for (int i = 0; i < 8; i++) begin
			chk("reply byte", hm.rq[i], e[i]);
			s = s + hm.rq[i];
		end
		chk("reply sum", hm.rq[8], s);
		chk("host pc", pc, st == flow_pkg::STATUS_OK ? v : p);
	endtask
	initial begin
		{err_position, err_deviation, err_alarm, err_timeout} = 4'h0;
		{flag_lower, flag_greater, flag_equal, flag_zero} = 4'h0;
		repeat (5) @(negedge mclk);
		nrst = 1'b1;
		t_restart(32'h0000_000a);
		t_cond(8'h00);
		t_restart(32'h0000_0020);
		t_cond(8'hff);
		t_restart(32'h0000_0030);
		t_dec();
		t_restart(32'h0000_0040);
		t_host(flow_pkg::OP_RESTART, 32'h0000_000a, 1'b0, flow_pkg::STATUS_OK, 32'h0000_000a);
		t_host(flow_pkg::OP_RESTART, 32'h0000_0055, 1'b1, flow_pkg::STATUS_BAD_SUM,
			32'h0000_0055);
		t_host(8'h2e, 32'h0000_0000, 1'b0, flow_pkg::STATUS_BAD_CMD, 32'h0000_0000);
		t_host(flow_pkg::OP_DEC_BRANCH, 32'h0000_0077, 1'b0, flow_pkg::STATUS_OK,
			32'hffff_ffff);
		test_done();
	end
endmodule
